// file: src/sop_pkg.sv
// constants and types for the safe output and preset control block
package sop_pkg;
    // system clock and supply monitor timing
    localparam int CLK_HZ = 250_000_000;
    localparam int OV_TIME_MS = 200;
    localparam int OV_CYCLES = OV_TIME_MS * (CLK_HZ / 1000);

    // register byte offsets
    localparam logic [7:0] ADR_DEV_LIMIT = 8'h00;
    localparam logic [7:0] ADR_STANDSTILL = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_FAULT = 8'h0C;

    // deviation limit in increments, reset value and legal range
    localparam logic [15:0] DEV_LIMIT_RST = 16'h03E8;
    localparam logic [15:0] DEV_LIMIT_MIN = 16'h0032;
    localparam logic [15:0] DEV_LIMIT_MAX = 16'h0FA0;

    // standstill tolerance in increments per integration interval
    localparam logic [2:0] TOL_RST = 3'h1;
    localparam logic [2:0] TOL_MIN = 3'h1;
    localparam logic [2:0] TOL_MAX = 3'h5;

    // status register bit positions
    localparam int ST_SAFETY_OK = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_DONE = 2;
    localparam int ST_REJECTED = 3;
    localparam int ST_PASSIVE = 4;
    localparam int ST_PD_PASSIVE = 5;
    localparam int ST_STARTUP = 6;
    localparam int ST_STATE = 8;

    // latched fault bit positions
    localparam int FLT_COMM = 0;
    localparam int FLT_DEV = 1;
    localparam int FLT_TELEGRAM = 2;
    localparam int FLT_OVERVOLT = 3;
    localparam int FLT_HW = 4;
    localparam int FLT_SPEED = 5;
    localparam int FLT_W = 6;

    typedef enum logic [2:0] {
        P_IDLE, P_ARMED, P_CHECK, P_WAIT
    } sop_preset_e;

    typedef enum logic [1:0] {
        RUN_OFF, RUN_ON, RUN_DFLASH
    } sop_run_e;
endpackage

// file: src/sop_top.sv
// safe output passivation and preset handshake with a wishbone slave
// How it works
// - from reset until the safety session first runs, safe outputs are zero
// - a safety communication error passivates the safe outputs
// - channel deviation above limit or a bad telegram passivates outputs
// - overvoltage held longer than 200 ms passivates the safe outputs
// - any internal hardware fault passivates the safe outputs
// - dual scanning variant passivates on the overspeed trip
// - with clean primary diagnosis the process channel stays live
// - a primary diagnosis error zeroes the process channel, not the safe outputs
// - prepare high clears the safety ok flag; master goes safe
// - trigger rising edge captures the preset and sets active
// - active returns to zero when execution has finished
// - preconditions checked; if met, captured value loads as position
// - failed precondition: no load, rejected flag set
// - successful preset sets the done flag
// - prepare back to zero restores the safety ok flag
// - link indicator lit only when ready with ethernet link up
// - drop from operational to safe_op changes run indicator to double flash
// - preset rejected unless speed within standstill tolerance 1 to 5
// - deviation limit 50 to 4000 increments, default 1000
`timescale 1ns/10ps
module sop_top import sop_pkg::*; #(
    parameter int POS_W = 16,
    parameter int OV_LIMIT = OV_CYCLES,
    parameter bit DUAL_MAG = 1'b1
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [3:0] SEL_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // live position and diagnosis from the sensing logic
    input wire logic [POS_W-1:0] POS_TURNS,
    input wire logic [POS_W-1:0] POS_WITHIN,
    input wire logic [15:0] CH_DEVIATION,
    input wire logic [15:0] SPEED_INC,
    input wire logic TELEGRAM_BAD,
    input wire logic HW_FAULT,
    input wire logic OVERSPEED,
    input wire logic PRIMARY_DIAG_ERR,
    // supply monitor pin, asynchronous
    input wire logic OVERVOLT_PIN,
    // safety protocol stack
    input wire logic SAFE_SESSION_UP,
    input wire logic COMM_ERR,
    input wire logic ERR_ACK,
    input wire logic PRESET_PREPARE,
    input wire logic PRESET_TRIGGER,
    input wire logic [POS_W-1:0] PRESET_VALUE_TURNS,
    input wire logic [POS_W-1:0] PRESET_VALUE_WITHIN_TURN,
    // fieldbus state for indicators
    input wire logic DEV_READY,
    input wire logic ETH_LINK,
    input wire logic BUS_OP,
    input wire logic BUS_SAFE_OP,
    // safe channel data and status
    output logic [POS_W-1:0] SAFE_TURNS,
    output logic [POS_W-1:0] SAFE_WITHIN,
    output logic SAFE_PASSIVE,
    output logic SAFETY_OK_FLAG,
    output logic PRESET_ACTIVE,
    output logic PRESET_DONE,
    output logic PRESET_REJECTED,
    // non-safe process data channel
    output logic [POS_W-1:0] PD_TURNS,
    output logic [POS_W-1:0] PD_WITHIN,
    // new position load towards the sensing logic
    output logic LOAD_STB,
    output logic [POS_W-1:0] LOAD_TURNS,
    output logic [POS_W-1:0] LOAD_WITHIN,
    // indicators
    output logic LINK_LED,
    output logic [1:0] RUN_LED_MODE
);
    localparam int OVC_W = $clog2(OV_LIMIT + 1);

    // refused at elaboration, before any logic is built
    if (POS_W < 1 || POS_W > 32) begin : g_bad_pos_w
        $error("POS_W must lie in 1..32");
    end
    if (OV_LIMIT < 1) begin : g_bad_ov_limit
        $error("OV_LIMIT must be at least one cycle");
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wr,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? wr[15:8] : old[15:8], sel[0] ? wr[7:0] : old[7:0]};
    endfunction

    // ---------------- wishbone slave ----------------
    logic ack_q;
    logic [31:0] dat_q;
    logic [15:0] dev_limit_q;
    logic [2:0] tol_q;
    wire bus_req = CYC_I & STB_I & ~ack_q;
    wire bus_wr = bus_req & WE_I;
    wire wr_dev = bus_wr & (ADR_I == ADR_DEV_LIMIT);
    wire wr_tol = bus_wr & (ADR_I == ADR_STANDSTILL) & SEL_I[0];
    wire wr_flt = bus_wr & (ADR_I == ADR_FAULT) & SEL_I[0];
    wire [15:0] dev_new = merge16(dev_limit_q, DAT_I[15:0], SEL_I[1:0]);
    wire [2:0] tol_new = DAT_I[2:0];
    // out-of-range values are dropped so the limits stay legal
    wire dev_ok = (dev_new >= DEV_LIMIT_MIN) && (dev_new <= DEV_LIMIT_MAX);
    wire tol_ok = (tol_new >= TOL_MIN) && (tol_new <= TOL_MAX)
        && (DAT_I[7:3] == 5'h00);

    logic [FLT_W-1:0] flt_q;
    logic [31:0] status_w;
    logic [31:0] rd_w;
    always_comb begin
        case (ADR_I)
            ADR_DEV_LIMIT: rd_w = {16'h0000, dev_limit_q};
            ADR_STANDSTILL: rd_w = {29'h0000_0000, tol_q};
            ADR_STATUS: rd_w = status_w;
            ADR_FAULT: rd_w = {{(32-FLT_W){1'b0}}, flt_q};
            default: rd_w = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            dev_limit_q <= DEV_LIMIT_RST;
            tol_q <= TOL_RST;
        end else begin
            ack_q <= bus_req;
            dat_q <= bus_req ? rd_w : 32'h0000_0000;
            if (wr_dev && dev_ok) begin
                dev_limit_q <= dev_new;
            end
            if (wr_tol && tol_ok) begin
                tol_q <= tol_new;
            end
        end
    end
    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    // ---------------- overvoltage filter ----------------
    logic ov_s1_q;
    logic ov_s2_q;
    logic [OVC_W-1:0] ov_cnt_q;
    wire [OVC_W-1:0] ov_last = OVC_W'(OV_LIMIT - 1);
    wire ov_trip = ov_s2_q & (ov_cnt_q == ov_last);
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ov_s1_q <= 1'b0;
            ov_s2_q <= 1'b0;
            ov_cnt_q <= '0;
        end else begin
            ov_s1_q <= OVERVOLT_PIN;
            ov_s2_q <= ov_s1_q;
            if (!ov_s2_q) begin
                ov_cnt_q <= '0;
            end else if (!ov_trip) begin
                ov_cnt_q <= ov_cnt_q + OVC_W'(1);
            end
        end
    end

    // ---------------- passivation ----------------
    logic startup_q;
    wire dev_exceed = CH_DEVIATION > dev_limit_q;
    wire [FLT_W-1:0] flt_set = {
        DUAL_MAG & OVERSPEED,
        HW_FAULT,
        ov_trip,
        TELEGRAM_BAD,
        dev_exceed,
        COMM_ERR
    };
    // a fault still present wins over the clear, so it cannot be lost
    wire [FLT_W-1:0] flt_clr = (wr_flt ? DAT_I[FLT_W-1:0] : '0)
        | {FLT_W{ERR_ACK}};
    wire passive_w = startup_q | (|flt_q);

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            startup_q <= 1'b1;
            flt_q <= '0;
        end else begin
            if (SAFE_SESSION_UP) begin
                startup_q <= 1'b0;
            end
            flt_q <= (flt_q & ~flt_clr) | flt_set;
        end
    end

    // ---------------- preset handshake ----------------
    sop_preset_e st_q;
    sop_preset_e st_d;
    logic trig_q;
    logic active_q;
    logic done_q;
    logic rej_q;
    logic safety_ok_q;
    logic [POS_W-1:0] cap_turns_q;
    logic [POS_W-1:0] cap_within_q;
    logic load_q;
    logic [POS_W-1:0] load_turns_q;
    logic [POS_W-1:0] load_within_q;
    // relies on the master holding the trigger low while arming
    wire trig_rise = PRESET_TRIGGER & ~trig_q;
    wire standstill = SPEED_INC <= {13'h0000, tol_q};
    wire preset_ok = standstill & ~passive_w & PRESET_PREPARE;

    always_comb begin
        st_d = st_q;
        case (st_q)
            P_IDLE: if (PRESET_PREPARE) st_d = P_ARMED;
            P_ARMED: begin
                if (!PRESET_PREPARE) begin
                    st_d = P_IDLE;
                end else if (trig_rise) begin
                    st_d = P_CHECK;
                end
            end
            P_CHECK: st_d = P_WAIT;
            P_WAIT: if (!PRESET_PREPARE) st_d = P_IDLE;
            default: st_d = P_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_q <= P_IDLE;
            trig_q <= 1'b0;
            active_q <= 1'b0;
            done_q <= 1'b0;
            rej_q <= 1'b0;
            safety_ok_q <= 1'b0;
            cap_turns_q <= '0;
            cap_within_q <= '0;
            load_q <= 1'b0;
            load_turns_q <= '0;
            load_within_q <= '0;
        end else begin
            st_q <= st_d;
            trig_q <= PRESET_TRIGGER;
            load_q <= 1'b0;
            safety_ok_q <= ~PRESET_PREPARE & ~passive_w;
            if (st_q == P_IDLE && PRESET_PREPARE) begin
                done_q <= 1'b0;
                rej_q <= 1'b0;
            end
            if (st_q == P_ARMED && PRESET_PREPARE && trig_rise) begin
                cap_turns_q <= PRESET_VALUE_TURNS;
                cap_within_q <= PRESET_VALUE_WITHIN_TURN;
                active_q <= 1'b1;
            end
            if (st_q == P_CHECK) begin
                active_q <= 1'b0;
                if (preset_ok) begin
                    load_q <= 1'b1;
                    load_turns_q <= cap_turns_q;
                    load_within_q <= cap_within_q;
                    done_q <= 1'b1;
                end else begin
                    rej_q <= 1'b1;
                end
            end
        end
    end

    // ---------------- data channels and indicators ----------------
    logic [POS_W-1:0] safe_turns_q;
    logic [POS_W-1:0] safe_within_q;
    logic [POS_W-1:0] pd_turns_q;
    logic [POS_W-1:0] pd_within_q;
    logic passive_q;
    logic link_q;
    logic was_op_q;
    sop_run_e run_q;
    wire pd_passive = PRIMARY_DIAG_ERR;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            safe_turns_q <= '0;
            safe_within_q <= '0;
            pd_turns_q <= '0;
            pd_within_q <= '0;
            passive_q <= 1'b1;
            link_q <= 1'b0;
            was_op_q <= 1'b0;
            run_q <= RUN_OFF;
        end else begin
            passive_q <= passive_w;
            safe_turns_q <= passive_w ? '0 : POS_TURNS;
            safe_within_q <= passive_w ? '0 : POS_WITHIN;
            pd_turns_q <= pd_passive ? '0 : POS_TURNS;
            pd_within_q <= pd_passive ? '0 : POS_WITHIN;
            link_q <= DEV_READY & ETH_LINK;
            if (BUS_OP) begin
                was_op_q <= 1'b1;
                run_q <= RUN_ON;
            end else if (BUS_SAFE_OP && was_op_q) begin
                run_q <= RUN_DFLASH;
            end else begin
                was_op_q <= 1'b0;
                run_q <= RUN_OFF;
            end
        end
    end

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_SAFETY_OK] = safety_ok_q;
        status_w[ST_ACTIVE] = active_q;
        status_w[ST_DONE] = done_q;
        status_w[ST_REJECTED] = rej_q;
        status_w[ST_PASSIVE] = passive_q;
        status_w[ST_PD_PASSIVE] = pd_passive;
        status_w[ST_STARTUP] = startup_q;
        status_w[ST_STATE +: 3] = st_q;
    end

    assign SAFE_TURNS = safe_turns_q;
    assign SAFE_WITHIN = safe_within_q;
    assign SAFE_PASSIVE = passive_q;
    assign SAFETY_OK_FLAG = safety_ok_q;
    assign PRESET_ACTIVE = active_q;
    assign PRESET_DONE = done_q;
    assign PRESET_REJECTED = rej_q;
    assign PD_TURNS = pd_turns_q;
    assign PD_WITHIN = pd_within_q;
    assign LOAD_STB = load_q;
    assign LOAD_TURNS = load_turns_q;
    assign LOAD_WITHIN = load_within_q;
    assign LINK_LED = link_q;
    assign RUN_LED_MODE = run_q;

    // ---------------- checks ----------------
    property p_startup_zero;
        @(posedge MCLK) disable iff (RST)
        startup_q |=> SAFE_PASSIVE && SAFE_TURNS == '0 && SAFE_WITHIN == '0;
    endproperty
    a_startup_zero: assert property (p_startup_zero)
        else $error("safe data not zero during start-up");

    property p_comm_err;
        @(posedge MCLK) disable iff (RST)
        COMM_ERR |=> flt_q[FLT_COMM] ##1 SAFE_PASSIVE;
    endproperty
    a_comm_err: assert property (p_comm_err)
        else $error("comm error did not passivate");

    property p_deviation;
        @(posedge MCLK) disable iff (RST)
        (CH_DEVIATION > dev_limit_q) |=> ##1 SAFE_TURNS == '0;
    endproperty
    a_deviation: assert property (p_deviation)
        else $error("deviation above limit left live data");

    property p_overvolt;
        @(posedge MCLK) disable iff (RST)
        (ov_s2_q && ov_cnt_q == ov_last) |=> flt_q[FLT_OVERVOLT];
    endproperty
    a_overvolt: assert property (p_overvolt)
        else $error("overvoltage trip not latched");

    property p_hw_fault;
        @(posedge MCLK) disable iff (RST)
        HW_FAULT |=> ##1 SAFE_PASSIVE && SAFE_WITHIN == '0;
    endproperty
    a_hw_fault: assert property (p_hw_fault)
        else $error("hardware fault left live data");

    property p_pd_channel;
        @(posedge MCLK) disable iff (RST)
        !PRIMARY_DIAG_ERR |=> PD_TURNS == $past(POS_TURNS);
    endproperty
    a_pd_channel: assert property (p_pd_channel)
        else $error("process channel not live");

    property p_pd_passive;
        @(posedge MCLK) disable iff (RST)
        PRIMARY_DIAG_ERR |=> PD_TURNS == '0 && PD_WITHIN == '0;
    endproperty
    a_pd_passive: assert property (p_pd_passive)
        else $error("process channel not zeroed on diagnosis error");

    property p_prepare_clears;
        @(posedge MCLK) disable iff (RST)
        $rose(PRESET_PREPARE) |=> !SAFETY_OK_FLAG;
    endproperty
    a_prepare_clears: assert property (p_prepare_clears)
        else $error("safety ok not cleared by prepare");

    property p_trigger_ack;
        @(posedge MCLK) disable iff (RST)
        (st_q == P_ARMED && PRESET_PREPARE && trig_rise)
            |=> PRESET_ACTIVE ##1 !PRESET_ACTIVE;
    endproperty
    a_trigger_ack: assert property (p_trigger_ack)
        else $error("trigger edge not acknowledged for one cycle");

    property p_outcome;
        @(posedge MCLK) disable iff (RST)
        st_q == P_CHECK |=> (PRESET_DONE ^ PRESET_REJECTED)
            && (LOAD_STB == PRESET_DONE);
    endproperty
    a_outcome: assert property (p_outcome)
        else $error("preset outcome flags inconsistent");

    property p_arm_clears;
        @(posedge MCLK) disable iff (RST)
        (st_q == P_IDLE && PRESET_PREPARE)
            |=> !PRESET_DONE && !PRESET_REJECTED;
    endproperty
    a_arm_clears: assert property (p_arm_clears)
        else $error("arming did not clear outcome flags");
endmodule // sop_top

// file: test/sop_master_model.sv
// behavioural safety master that runs the preset handshake
`timescale 1ns/10ps
module sop_master_model (
    // clock
    input wire logic MCLK,
    // status from the device
    input wire logic SAFETY_OK_FLAG,
    input wire logic PRESET_ACTIVE,
    input wire logic PRESET_DONE,
    input wire logic PRESET_REJECTED,
    input wire logic [15:0] SAFE_TURNS,
    input wire logic [15:0] SAFE_WITHIN,
    // control to the device
    output logic PRESET_PREPARE,
    output logic PRESET_TRIGGER,
    output logic [15:0] PRESET_VALUE_TURNS,
    output logic [15:0] PRESET_VALUE_WITHIN_TURN
);
    initial begin
        PRESET_PREPARE = 1'b0;
        PRESET_TRIGGER = 1'b0;
        PRESET_VALUE_TURNS = 16'h0000;
        PRESET_VALUE_WITHIN_TURN = 16'h0000;
    end

    // bounded wait for one status bit; a slow device just costs edges
    task automatic see(input int s, input logic lvl, output logic hit);
        logic [2:0] st;
        hit = 1'b0;
        for (int n = 0; n < 12 && !hit; n++) begin
            @(posedge MCLK);
            st = {PRESET_REJECTED | PRESET_DONE, PRESET_ACTIVE, SAFETY_OK_FLAG};
            hit = (st[s] === lvl);
        end
    endtask

    // one whole sequence; seen reports each answer of the device
    task automatic run(input logic [31:0] v, output logic [4:0] seen);
        @(posedge MCLK);
        PRESET_PREPARE <= 1'b0;
        PRESET_TRIGGER <= 1'b0;
        {PRESET_VALUE_TURNS, PRESET_VALUE_WITHIN_TURN} <= v;
        repeat (2) @(posedge MCLK);
        PRESET_PREPARE <= 1'b1;
        see(0, 1'b0, seen[0]);
        PRESET_TRIGGER <= 1'b1;
        see(1, 1'b1, seen[1]);
        see(2, 1'b1, seen[2]);
        PRESET_TRIGGER <= 1'b0;
        @(posedge MCLK);
        PRESET_PREPARE <= 1'b0;
        see(0, 1'b1, seen[3]);
        repeat (3) @(posedge MCLK);
        seen[4] = ({SAFE_TURNS, SAFE_WITHIN} === v);
    endtask
endmodule // sop_master_model

// file: test/sop_tb_top.sv
// self-checking testbench for the safe output and preset block
`timescale 1ns/10ps
module sop_tb_top import sop_pkg::*;;
    logic MCLK, RST, CYC_I, STB_I, WE_I, ACK_O;
    logic [7:0] ADR_I;
    logic [31:0] DAT_I, DAT_O;
    logic [3:0] SEL_I;
    logic TELEGRAM_BAD, HW_FAULT, OVERSPEED, PRIMARY_DIAG_ERR;
    logic OVERVOLT_PIN, SAFE_SESSION_UP, COMM_ERR, ERR_ACK;
    logic DEV_READY, ETH_LINK, BUS_OP, BUS_SAFE_OP;
    logic PRESET_PREPARE, PRESET_TRIGGER, SAFE_PASSIVE, SAFETY_OK_FLAG;
    logic PRESET_ACTIVE, PRESET_DONE, PRESET_REJECTED, LOAD_STB, LINK_LED;
    logic [15:0] POS_TURNS, POS_WITHIN, CH_DEVIATION, SPEED_INC;
    logic [15:0] PRESET_VALUE_TURNS, PRESET_VALUE_WITHIN_TURN;
    logic [15:0] SAFE_TURNS, SAFE_WITHIN, PD_TURNS, PD_WITHIN;
    logic [15:0] LOAD_TURNS, LOAD_WITHIN;
    logic [1:0] RUN_LED_MODE;
    logic [31:0] rq[$];
    logic [32:0] pq[$];
    logic [31:0] rnd, pos;
    logic [4:0] seen;
    logic rej_q;
    int errors, check_count;
    // address, written data, expected read back
    logic [7:0] ta[8] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h04, 8'h04, 8'h04, 8'h10};
    logic [15:0] td[8] = '{16'h0031, 16'h0FA1, 16'h0032, 16'h0FA0,
        16'h0000, 16'h0006, 16'h0005, 16'h0005};
    logic [15:0] te[8] = '{16'h03E8, 16'h03E8, 16'h0032, 16'h0FA0,
        16'h0001, 16'h0001, 16'h0005, 16'h0000};

    sop_top #(.POS_W(16), .OV_LIMIT(8), .DUAL_MAG(1'b1)) sop_top_i (
        .MCLK(MCLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .DAT_I(DAT_I), .SEL_I(SEL_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O), .POS_TURNS(POS_TURNS), .POS_WITHIN(POS_WITHIN),
        .CH_DEVIATION(CH_DEVIATION), .SPEED_INC(SPEED_INC),
        .TELEGRAM_BAD(TELEGRAM_BAD), .HW_FAULT(HW_FAULT),
        .OVERSPEED(OVERSPEED), .PRIMARY_DIAG_ERR(PRIMARY_DIAG_ERR),
        .OVERVOLT_PIN(OVERVOLT_PIN), .SAFE_SESSION_UP(SAFE_SESSION_UP),
        .COMM_ERR(COMM_ERR), .ERR_ACK(ERR_ACK),
        .PRESET_PREPARE(PRESET_PREPARE), .PRESET_TRIGGER(PRESET_TRIGGER),
        .PRESET_VALUE_TURNS(PRESET_VALUE_TURNS),
        .PRESET_VALUE_WITHIN_TURN(PRESET_VALUE_WITHIN_TURN),
        .DEV_READY(DEV_READY), .ETH_LINK(ETH_LINK), .BUS_OP(BUS_OP),
        .BUS_SAFE_OP(BUS_SAFE_OP), .SAFE_TURNS(SAFE_TURNS),
        .SAFE_WITHIN(SAFE_WITHIN), .SAFE_PASSIVE(SAFE_PASSIVE),
        .SAFETY_OK_FLAG(SAFETY_OK_FLAG), .PRESET_ACTIVE(PRESET_ACTIVE),
        .PRESET_DONE(PRESET_DONE), .PRESET_REJECTED(PRESET_REJECTED),
        .PD_TURNS(PD_TURNS), .PD_WITHIN(PD_WITHIN), .LOAD_STB(LOAD_STB),
        .LOAD_TURNS(LOAD_TURNS), .LOAD_WITHIN(LOAD_WITHIN),
        .LINK_LED(LINK_LED), .RUN_LED_MODE(RUN_LED_MODE)
    );

    sop_master_model sop_master_model_i (
        .MCLK(MCLK), .SAFETY_OK_FLAG(SAFETY_OK_FLAG),
        .PRESET_ACTIVE(PRESET_ACTIVE), .PRESET_DONE(PRESET_DONE),
        .PRESET_REJECTED(PRESET_REJECTED), .SAFE_TURNS(SAFE_TURNS),
        .SAFE_WITHIN(SAFE_WITHIN), .PRESET_PREPARE(PRESET_PREPARE),
        .PRESET_TRIGGER(PRESET_TRIGGER),
        .PRESET_VALUE_TURNS(PRESET_VALUE_TURNS),
        .PRESET_VALUE_WITHIN_TURN(PRESET_VALUE_WITHIN_TURN)
    );

    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge MCLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= a;
        DAT_I <= d;
        SEL_I <= 4'hF;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 40);
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        if (ACK_O !== 1'b1) begin
            errors++;
            test_done();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    // monitor: read data on ack, preset outcome on load or reject
    always @(posedge MCLK) begin
        rej_q <= PRESET_REJECTED;
        if (ACK_O === 1'b1 && WE_I === 1'b0) begin
            if (rq.size() == 0) chk("read queue", 33'h0, 33'h1);
            else chk("read data", {1'b0, rq.pop_front()}, {1'b0, DAT_O});
        end
        if (LOAD_STB === 1'b1 || {PRESET_REJECTED, rej_q} === 2'b10) begin
            pos = {LOAD_TURNS, LOAD_WITHIN};
            if (pq.size() == 0) chk("preset queue", 33'h0, 33'h1);
            else if (LOAD_STB === 1'b1)
                chk("load", pq.pop_front(), {1'b0, pos});
            else chk("reject", pq.pop_front(), {1'b1, 32'h0000_0000});
        end
    end

    // stands in for the sensing logic taking the new position
    always @(posedge MCLK) begin
        if (LOAD_STB === 1'b1) begin
            POS_TURNS <= LOAD_TURNS;
            POS_WITHIN <= LOAD_WITHIN;
        end
    end

    initial begin
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I, SEL_I} = '0;
        {TELEGRAM_BAD, HW_FAULT, OVERSPEED, PRIMARY_DIAG_ERR} = '0;
        {OVERVOLT_PIN, SAFE_SESSION_UP, COMM_ERR, ERR_ACK} = '0;
        {DEV_READY, ETH_LINK, BUS_OP, BUS_SAFE_OP} = '0;
        {POS_TURNS, POS_WITHIN, CH_DEVIATION, SPEED_INC} = '0;
        errors = 0;
        check_count = 0;
        RST = 1'b1;
        cyc(10);
        RST <= 1'b0;
        rd(ADR_DEV_LIMIT, 32'h0000_03E8);
        rd(ADR_STANDSTILL, 32'h0000_0001);
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, ta[k], {16'h0000, td[k]});
            rd(ta[k], {16'h0000, te[k]});
        end
        rnd = xs(32'h0000_0003);
        {POS_TURNS, POS_WITHIN} <= rnd;
        cyc(4);
        chk("start passive", 1'b1, SAFE_PASSIVE);
        chk("start data", 33'h0, {SAFE_TURNS, SAFE_WITHIN});
        SAFE_SESSION_UP <= 1'b1;
        cyc(6);
        chk("live data", {1'b0, rnd}, {SAFE_TURNS, SAFE_WITHIN});
        for (int k = 0; k < 6; k++) begin
            case (k)
                0: COMM_ERR <= 1'b1;
                1: CH_DEVIATION <= 16'h0FA1;
                2: TELEGRAM_BAD <= 1'b1;
                3: OVERVOLT_PIN <= 1'b1;
                4: HW_FAULT <= 1'b1;
                default: OVERSPEED <= 1'b1;
            endcase
            cyc(20);
            chk("passive", 1'b1, SAFE_PASSIVE);
            chk("fault data", 33'h0, {SAFE_TURNS, SAFE_WITHIN});
            chk("pd live", {1'b0, rnd}, {PD_TURNS, PD_WITHIN});
            rd(ADR_FAULT, 32'h0000_0001 << k);
            {COMM_ERR, TELEGRAM_BAD, OVERVOLT_PIN, HW_FAULT} <= '0;
            OVERSPEED <= 1'b0;
            CH_DEVIATION <= 16'h0000;
            cyc(4);
            // odd faults are cleared through the write-one-to-clear path
            if (k[0]) begin
                wb(1'b1, ADR_FAULT, 32'h0000_003F);
            end else begin
                ERR_ACK <= 1'b1;
                cyc(1);
                ERR_ACK <= 1'b0;
            end
            cyc(6);
            chk("recovered", 1'b0, SAFE_PASSIVE);
        end
        PRIMARY_DIAG_ERR <= 1'b1;
        cyc(3);
        chk("pd passive", 33'h0, {PD_TURNS, PD_WITHIN});
        PRIMARY_DIAG_ERR <= 1'b0;
        SPEED_INC <= 16'h0006;
        pq.push_back({1'b1, 32'h0000_0000});
        sop_master_model_i.run(xs(rnd), seen);
        chk("reject walk", 4'hF, seen[3:0]);
        chk("no done", 1'b0, PRESET_DONE);
        SPEED_INC <= 16'h0005;
        rnd = xs(xs(rnd));
        pq.push_back({1'b0, rnd});
        sop_master_model_i.run(rnd, seen);
        chk("preset walk", 5'h1F, seen);
        chk("active low", 1'b0, PRESET_ACTIVE);
        chk("done", 1'b1, PRESET_DONE);
        chk("rej cleared", 1'b0, PRESET_REJECTED);
        rd(ADR_STATUS, (32'h0000_0001 << ST_SAFETY_OK)
            | (32'h0000_0001 << ST_DONE));
        DEV_READY <= 1'b1;
        cyc(3);
        chk("link off", 1'b0, LINK_LED);
        ETH_LINK <= 1'b1;
        BUS_OP <= 1'b1;
        cyc(3);
        chk("link on", 1'b1, LINK_LED);
        chk("run on", 2'h1, RUN_LED_MODE);
        BUS_OP <= 1'b0;
        BUS_SAFE_OP <= 1'b1;
        cyc(3);
        chk("run dflash", 2'h2, RUN_LED_MODE);
        chk("queues", 33'h0, rq.size() + pq.size());
        test_done();
    end
endmodule // sop_tb_top
